// ===== rtl/tdf_pkg.sv
`default_nettype none
package tdf_pkg;
  // ****************************************************************
  // Training queue geometry
  // ****************************************************************
  localparam int FIFO_DEPTH = 6;
  localparam int PTR_W = 3;
  localparam int BURST_LEN = 8;
  localparam int BEAT_W = 3;
  localparam int BEATS_PER_CK = 4;
  localparam int WORD_W = 40;
  localparam int SCR_W = 10;
  localparam int LINK_W = 54;
  localparam int SCHED_W = 32;
  localparam int NUM_ENG = 3;
  localparam int ENG_DATA = 0;
  localparam int ENG_EDC = 1;
  localparam int ENG_WR = 2;
  // Word layout in the queue: data pins, inversion flags, error detect.
  localparam int DQ_LSB = 0;
  localparam int DBI_LSB = 32;
  localparam int EDC_LSB = 36;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LAT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_ID = 8'h0c;
  localparam int CTRL_RINV = 0;
  localparam int CTRL_WINV = 1;
  localparam int CTRL_RCHK = 2;
  localparam int CTRL_WCHK = 3;
  localparam int CTRL_RSTRB = 4;
  localparam int CTRL_TERM = 5;
  localparam int CTRL_HOLD = 8;
  localparam int LAT_COL = 0;
  localparam int LAT_CRD = 8;
  localparam int LAT_WR = 16;
  localparam int STAT_WPTR = 0;
  localparam int STAT_RPTR = 4;
  localparam int STAT_SCR = 8;
  localparam int STAT_ORDER = 12;
  localparam int STAT_MASK = 16;
  localparam int ID_DEPTH = 0;
  localparam int ID_CODE = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0020;
  localparam logic [31:0] LAT_RST = 32'h0003_0104;
endpackage : tdf_pkg
`default_nettype wire

// ===== rtl/tdf_store_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the write and read ports of the training queue storage.
interface tdf_store_if;
  import tdf_pkg::*;
  logic commitEn;
  logic [PTR_W-1:0] commitStage;
  logic [BURST_LEN-1:0][WORD_W-1:0] commitData;
  logic beatWrEn;
  logic [PTR_W-1:0] beatStage;
  logic [BEAT_W-1:0] beatIdx;
  logic [WORD_W-1:0] beatWord;
  logic [PTR_W-1:0] rdStageA;
  logic [BEAT_W-1:0] rdBeatA;
  logic [WORD_W-1:0] rdWordA;
  logic [PTR_W-1:0] rdStageB;
  logic [BEAT_W-1:0] rdBeatB;
  logic [WORD_W-1:0] rdWordB;
  modport ctl(output commitEn, commitStage, commitData, beatWrEn, beatStage,
    beatIdx, beatWord, rdStageA, rdBeatA, rdStageB, rdBeatB,
    input rdWordA, rdWordB);
  modport mem(input commitEn, commitStage, commitData, beatWrEn, beatStage,
    beatIdx, beatWord, rdStageA, rdBeatA, rdStageB, rdBeatB,
    output rdWordA, rdWordB);
endinterface : tdf_store_if
`default_nettype wire

// ===== rtl/tdf_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; a bit changes once stages two and three agree.
module tdf_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

  // Bits where the last two stages differ keep their old value.
  always_comb begin
    q_nxt = (s3_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));
  end

  // The first stage is read only by the second.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign dout = q_r;
endmodule : tdf_sync
`default_nettype wire

// ===== rtl/tdf_store.sv
`timescale 1ns/1ps
`default_nettype none
// Storage of the training queue: stages of eight beat words each.
module tdf_store
  import tdf_pkg::*;
(
  input wire logic clk,
  tdf_store_if.mem st
);
  logic [WORD_W-1:0] mem [FIFO_DEPTH*BURST_LEN];

  // Maps a stage and a beat onto a word of the array.
  function automatic int wordIdx(logic [PTR_W-1:0] s, logic [BEAT_W-1:0] b);
    return int'(s) * BURST_LEN + int'(b);
  endfunction : wordIdx

  // A commit writes a whole stage; otherwise a single beat may be written.
  always_ff @(posedge clk) begin
    if (st.commitEn) begin
      for (int b = 0; b < BURST_LEN; b++) begin
        mem[wordIdx(st.commitStage, BEAT_W'(b))] <= st.commitData[b];
      end
    end else if (st.beatWrEn) begin
      mem[wordIdx(st.beatStage, st.beatIdx)] <= st.beatWord;
    end
  end

  // Two independent read ports, one for data beats and one for detect bits.
  assign st.rdWordA = mem[wordIdx(st.rdStageA, st.rdBeatA)];
  assign st.rdWordB = mem[wordIdx(st.rdStageB, st.rdBeatB)];
endmodule : tdf_store
`default_nettype wire

// ===== rtl/tdf_training_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tdf_training_fifo
  import tdf_pkg::*;
#(
  parameter logic [7:0] VENDOR_CODE = 8'h5a // Arbitrary identity value.
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  input wire logic ckPin,
  input wire logic loadFifoCmdPin,
  input wire logic readTrainingCmdPin,
  input wire logic writeTrainingCmdPin,
  input wire logic [9:0] addrPin,
  input wire logic [3:0] burstPositionSelectPin,
  input wire logic [31:0] dqIn,
  input wire logic [3:0] inversionFlagIn,
  output logic [31:0] dqOut,
  output logic dqOe,
  output logic [3:0] inversionFlagOut,
  output logic inversionFlagOe,
  output logic [3:0] errorDetectOut,
  output logic errorDetectOe,
  output logic termOn
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [LINK_W-1:0] linkS;
  logic ckS, loadFifoCmd, readTrainingCmd, writeTrainingCmd;
  logic [9:0] addrS;
  logic [3:0] bankS;
  logic [31:0] dqS;
  logic [3:0] flagS;
  logic ckPrev_r, ckRise, tick;
  logic [7:0] perCnt_r, perCnt_nxt, perLen_r, perLen_nxt, pc1, quarter;
  logic [NUM_ENG-1:0] engActive, engStart, engDone;
  logic [NUM_ENG-1:0][BEAT_W-1:0] engBeat;
  logic [31:0] ctrl_r, ctrl_nxt, lat_r, lat_nxt, wbDatO_r, wbDatO_nxt;
  logic wbAck_r, wbAck_nxt, wbReq, wbWr, statClr;
  logic [PTR_W-1:0] wrPtr_r, wrPtr_nxt, dataPtr_r, dataPtr_nxt;
  logic [PTR_W-1:0] edcPtr_r, edcPtr_nxt;
  logic [BURST_LEN-1:0][SCR_W-1:0] scratch_r, scratch_nxt;
  logic [BURST_LEN-1:0] loadMask_r, loadMask_nxt;
  logic scratchValid_r, scratchValid_nxt, orderErr_r, orderErr_nxt;
  logic [SCR_W-1:0] loadByte;
  logic [BEAT_W-1:0] loadPos;
  logic loadSeven, postOnes_r, postOnes_nxt;
  logic readInvEn, writeInvEn, readChkEn, readStrobeMode, termEnable;
  logic [3:0] holdPattern;
  logic [31:0] dqOut_r, dqOut_nxt;
  logic [3:0] flagOut_r, flagOut_nxt, edcOut_r, edcOut_nxt;
  logic dqOe_r, dqOe_nxt, flagOe_r, flagOe_nxt, edcOe_r, edcOe_nxt;
  logic termOn_r, termOn_nxt;
  tdf_store_if st ();

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Steps a queue pointer and wraps it at the depth.
  function automatic logic [PTR_W-1:0] ptrInc(logic [PTR_W-1:0] p);
    return (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : ptrInc

  // Start delay of each engine in link clocks, never below one.
  function automatic logic [4:0] engDelay(logic [31:0] lat, int e);
    logic [5:0] s;
    s = {1'b0, lat[LAT_COL +: 5]};
    if (e == ENG_EDC) s = s + {1'b0, lat[LAT_CRD +: 5]};
    if (e == ENG_WR) s = {1'b0, lat[LAT_WR +: 5]};
    if (s == 6'h00) return 5'h01;
    if (s > 6'h1f) return 5'h1f;
    return s[4:0];
  endfunction : engDelay

  // Merges written bytes into a register under the byte selects.
  function automatic logic [31:0] byteMerge(logic [31:0] old,
      logic [31:0] val, logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = val[i*8 +: 8];
    end
    return r;
  endfunction : byteMerge

  // ****************************************************************
  // Link inputs and beat timing
  // ****************************************************************
  tdf_sync #(.W(LINK_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .din({ckPin, loadFifoCmdPin, readTrainingCmdPin, writeTrainingCmdPin,
      addrPin, burstPositionSelectPin, dqIn, inversionFlagIn}),
    .dout(linkS)
  );
  assign ckS = linkS[53];
  assign loadFifoCmd = linkS[52];
  assign readTrainingCmd = linkS[51];
  assign writeTrainingCmd = linkS[50];
  assign addrS = linkS[49:40];
  assign bankS = linkS[39:36];
  assign dqS = linkS[35:4];
  assign flagS = linkS[3:0];

  // Measures the link period and splits it into four beat ticks.
  always_comb begin
    ckRise = ckS & ~ckPrev_r;
    pc1 = perCnt_r + 8'h01;
    quarter = {2'b00, perLen_r[7:2]};
    tick = ckRise | ((quarter != 8'h00) & ((pc1 == quarter)
      | (pc1 == (quarter << 1)) | (pc1 == quarter + (quarter << 1))));
    perLen_nxt = ckRise ? pc1 : perLen_r;
    perCnt_nxt = ckRise ? 8'h00 : ((perCnt_r == 8'hff) ? perCnt_r : pc1);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ckPrev_r <= 1'b0;
      perCnt_r <= 8'h00;
      perLen_r <= 8'h00;
    end else if (ce) begin
      ckPrev_r <= ckS;
      perCnt_r <= perCnt_nxt;
      perLen_r <= perLen_nxt;
    end
  end

  // ****************************************************************
  // Burst engines: read data, read detect bits, write training
  // ****************************************************************
  for (genvar e = 0; e < NUM_ENG; e++) begin : g_eng
    logic [SCHED_W-1:0] sched_r, sched_nxt;
    logic act_r, act_nxt;
    logic [BEAT_W-1:0] beat_r, beat_nxt;
    logic trig;
    logic [4:0] dly;
    assign trig = ckRise & ((e == ENG_WR) ? writeTrainingCmd
      : readTrainingCmd);
    assign dly = engDelay(lat_r, e);
    assign engStart[e] = ckRise & sched_r[0];
    assign engDone[e] = tick & act_r & (beat_r == BEAT_W'(BURST_LEN - 1));
    assign engActive[e] = act_r;
    assign engBeat[e] = beat_r;

    // A restart on the last beat's closing tick joins bursts with no gap.
    always_comb begin
      sched_nxt = sched_r;
      if (ckRise) begin
        sched_nxt = sched_r >> 1;
        if (trig) sched_nxt[dly - 5'h01] = 1'b1;
      end
      act_nxt = act_r;
      beat_nxt = beat_r;
      if (engStart[e]) begin
        act_nxt = 1'b1;
        beat_nxt = '0;
      end else if (engDone[e]) begin
        act_nxt = 1'b0;
      end else if (tick & act_r) begin
        beat_nxt = beat_r + BEAT_W'(1);
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        sched_r <= '0;
        act_r <= 1'b0;
        beat_r <= '0;
      end else if (ce) begin
        sched_r <= sched_nxt;
        act_r <= act_nxt;
        beat_r <= beat_nxt;
      end
    end
  end

  // ****************************************************************
  // Load path, scratch pattern and queue pointers
  // ****************************************************************
  assign loadByte = {bankS[3], addrS[9], addrS[7:0]};
  assign loadPos = bankS[BEAT_W-1:0];
  assign loadSeven = ckRise & loadFifoCmd & (loadPos == BEAT_W'(7));

  // Loads fill the scratch; position seven commits it as a whole stage.
  always_comb begin
    logic [SCR_W-1:0] pat;
    pat = '0;
    scratch_nxt = scratch_r;
    loadMask_nxt = loadMask_r;
    scratchValid_nxt = scratchValid_r;
    orderErr_nxt = orderErr_r & ~statClr;
    if (ckRise & readTrainingCmd) begin
      loadMask_nxt = '0;
      scratchValid_nxt = 1'b0;
    end
    if (ckRise & loadFifoCmd) begin
      scratch_nxt[loadPos] = loadByte;
      loadMask_nxt[loadPos] = 1'b1;
      scratchValid_nxt = 1'b1;
      if (loadSeven & (loadMask_r[6:0] != 7'h7f)) orderErr_nxt = 1'b1;
    end
    st.commitEn = ce & loadSeven;
    st.commitStage = wrPtr_r;
    for (int b = 0; b < BURST_LEN; b++) begin
      pat = (b == BURST_LEN - 1) ? loadByte : scratch_r[b];
      st.commitData[b] = {{4{pat[9]}}, {4{pat[8]}}, {4{pat[7:0]}}};
    end
    st.beatWrEn = ce & tick & engActive[ENG_WR];
    st.beatStage = wrPtr_r;
    st.beatIdx = engBeat[ENG_WR];
    st.beatWord = {4'hf, writeInvEn ? flagS : 4'hf, dqS};
    st.rdStageA = dataPtr_r;
    st.rdBeatA = engBeat[ENG_DATA];
    st.rdStageB = edcPtr_r;
    st.rdBeatB = engBeat[ENG_EDC];
    wrPtr_nxt = (loadSeven | engDone[ENG_WR]) ? ptrInc(wrPtr_r) : wrPtr_r;
    dataPtr_nxt = engDone[ENG_DATA] ? ptrInc(dataPtr_r) : dataPtr_r;
    edcPtr_nxt = engDone[ENG_EDC] ? ptrInc(edcPtr_r) : edcPtr_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scratch_r <= '0;
      loadMask_r <= '0;
      scratchValid_r <= 1'b0;
      orderErr_r <= 1'b0;
      wrPtr_r <= '0;
      dataPtr_r <= '0;
      edcPtr_r <= '0;
    end else if (ce) begin
      scratch_r <= scratch_nxt;
      loadMask_r <= loadMask_nxt;
      scratchValid_r <= scratchValid_nxt;
      orderErr_r <= orderErr_nxt;
      wrPtr_r <= wrPtr_nxt;
      dataPtr_r <= dataPtr_nxt;
      edcPtr_r <= edcPtr_nxt;
    end
  end

  tdf_store u_store (
    .clk(clk),
    .st(st.mem)
  );

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  assign readInvEn = ctrl_r[CTRL_RINV];
  assign writeInvEn = ctrl_r[CTRL_WINV];
  assign readChkEn = ctrl_r[CTRL_RCHK];
  assign readStrobeMode = ctrl_r[CTRL_RSTRB];
  assign termEnable = ctrl_r[CTRL_TERM];
  assign holdPattern = ctrl_r[CTRL_HOLD +: 4];

  // Chooses burst data, the trailing ones beat, or termination.
  always_comb begin
    postOnes_nxt = tick ? (engDone[ENG_DATA] & ~engStart[ENG_DATA])
      : postOnes_r;
    dqOut_nxt = '0;
    dqOe_nxt = 1'b0;
    flagOut_nxt = '0;
    flagOe_nxt = 1'b0;
    termOn_nxt = termEnable;
    if (engActive[ENG_DATA]) begin
      dqOut_nxt = st.rdWordA[DQ_LSB +: 32];
      dqOe_nxt = 1'b1;
      termOn_nxt = 1'b0;
      flagOut_nxt = st.rdWordA[DBI_LSB +: 4];
      flagOe_nxt = readInvEn | readStrobeMode;
    end else if (postOnes_r) begin
      dqOut_nxt = '1;
      dqOe_nxt = 1'b1;
      flagOut_nxt = '1;
      flagOe_nxt = readInvEn | readStrobeMode;
      termOn_nxt = 1'b0;
    end
    edcOe_nxt = 1'b1;
    edcOut_nxt = holdPattern;
    if (readStrobeMode) begin
      edcOut_nxt = engActive[ENG_DATA] ? {4{~engBeat[ENG_DATA][0]}} : 4'h0;
    end else if (readChkEn & engActive[ENG_EDC]) begin
      edcOut_nxt = st.rdWordB[EDC_LSB +: 4];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      postOnes_r <= 1'b0;
      dqOut_r <= '0;
      dqOe_r <= 1'b0;
      flagOut_r <= '0;
      flagOe_r <= 1'b0;
      edcOut_r <= '0;
      edcOe_r <= 1'b0;
      termOn_r <= 1'b0;
    end else if (ce) begin
      postOnes_r <= postOnes_nxt;
      dqOut_r <= dqOut_nxt;
      dqOe_r <= dqOe_nxt;
      flagOut_r <= flagOut_nxt;
      flagOe_r <= flagOe_nxt;
      edcOut_r <= edcOut_nxt;
      edcOe_r <= edcOe_nxt;
      termOn_r <= termOn_nxt;
    end
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  assign wbReq = wbCyc & wbStb & ~wbAck_r;
  assign wbWr = wbReq & wbWe;
  assign statClr = wbWr & (wbAdr == REG_STAT) & wbSel[1] & wbDatI[STAT_ORDER];

  // Answers each request one cycle later; unmapped reads return zero.
  always_comb begin
    wbAck_nxt = wbReq;
    ctrl_nxt = ctrl_r;
    lat_nxt = lat_r;
    wbDatO_nxt = '0;
    if (wbWr & (wbAdr == REG_CTRL)) ctrl_nxt = byteMerge(ctrl_r, wbDatI, wbSel);
    if (wbWr & (wbAdr == REG_LAT)) lat_nxt = byteMerge(lat_r, wbDatI, wbSel);
    if (wbAdr == REG_CTRL) begin
      wbDatO_nxt = ctrl_r;
    end else if (wbAdr == REG_LAT) begin
      wbDatO_nxt = lat_r;
    end else if (wbAdr == REG_STAT) begin
      wbDatO_nxt[STAT_WPTR +: PTR_W] = wrPtr_r;
      wbDatO_nxt[STAT_RPTR +: PTR_W] = dataPtr_r;
      wbDatO_nxt[STAT_SCR] = scratchValid_r;
      wbDatO_nxt[STAT_ORDER] = orderErr_r;
      wbDatO_nxt[STAT_MASK +: BURST_LEN] = loadMask_r;
    end else if (wbAdr == REG_ID) begin
      wbDatO_nxt[ID_DEPTH +: PTR_W] = PTR_W'(FIFO_DEPTH);
      wbDatO_nxt[ID_CODE +: 8] = VENDOR_CODE;
    end
    if (!wbReq) wbDatO_nxt = '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wbAck_r <= 1'b0;
      wbDatO_r <= '0;
      ctrl_r <= CTRL_RST;
      lat_r <= LAT_RST;
    end else if (ce) begin
      wbAck_r <= wbAck_nxt;
      wbDatO_r <= wbDatO_nxt;
      ctrl_r <= ctrl_nxt;
      lat_r <= lat_nxt;
    end
  end

  assign wbAck = wbAck_r;
  assign wbDatO = wbDatO_r;
  assign dqOut = dqOut_r;
  assign dqOe = dqOe_r;
  assign inversionFlagOut = flagOut_r;
  assign inversionFlagOe = flagOe_r;
  assign errorDetectOut = edcOut_r;
  assign errorDetectOe = edcOe_r;
  assign termOn = termOn_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seqLoadSeven;
    ce && loadSeven;
  endsequence
  sequence seqReadCmd;
    ce && ckRise && readTrainingCmd;
  endsequence

  ptrWrap_a: assert property (seqLoadSeven |=>
    wrPtr_r == ptrInc($past(wrPtr_r))) else $error("load commit step wrong");
  depthWrap_a: assert property (wrPtr_r < PTR_W'(FIFO_DEPTH))
    else $error("write pointer beyond depth");
  scratchDrop_a: assert property (seqReadCmd ##0 !loadFifoCmd |=>
    !scratchValid_r && loadMask_r == '0) else $error("scratch kept");
  beatStep_a: assert property (ce && tick && engActive[ENG_DATA]
    && !engDone[ENG_DATA] |=> engBeat[ENG_DATA]
    == $past(engBeat[ENG_DATA]) + BEAT_W'(1)) else $error("beat skipped");
  burstDrive_a: assert property (ce && engActive[ENG_DATA] |=>
    dqOe && !termOn) else $error("data not driven in burst");
  gapless_a: assert property (ce && engDone[ENG_DATA]
    && engStart[ENG_DATA] |=> engActive[ENG_DATA]
    && engBeat[ENG_DATA] == '0) else $error("burst gap");
  trailOnes_a: assert property (ce && postOnes_r && !engActive[ENG_DATA]
    |=> dqOe && dqOut == '1) else $error("trailing ones missing");
  flagTerm_a: assert property (ce && !readInvEn && !readStrobeMode
    |=> !inversionFlagOe) else $error("flag driven while disabled");
  holdOut_a: assert property (ce && !readStrobeMode && !readChkEn
    |=> errorDetectOe && errorDetectOut == $past(holdPattern))
    else $error("hold pattern missing");
  busAck_a: assert property (ce && wbCyc && wbStb && !wbAck
    |=> wbAck ##1 !wbAck || !ce) else $error("bus answer wrong");
endmodule : tdf_training_fifo
`default_nettype wire

// ===== verification/tdf_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Controller model
// ****************************************************************
module tdf_ctl_model (
  output logic ckPin,
  output logic loadFifoCmdPin,
  output logic readTrainingCmdPin,
  output logic writeTrainingCmdPin,
  output logic [9:0] addrPin,
  output logic [3:0] burstPositionSelectPin
);
  // The link clock runs freely because beat timing derives from its period.
  initial begin
    ckPin = 1'b0;
    forever #62.5 ckPin = ~ckPin;
  end
  initial begin
    {loadFifoCmdPin, readTrainingCmdPin, writeTrainingCmdPin} = 3'b000;
    addrPin = 10'h000;
    burstPositionSelectPin = 4'h0;
  end
  // Holds one command for a full period around a rising edge.
  task automatic cmd(input logic [2:0] kind, input logic [9:0] a,
    input logic [3:0] b, input int gap);
    @(negedge ckPin);
    {loadFifoCmdPin, readTrainingCmdPin, writeTrainingCmdPin} <= kind;
    addrPin <= a;
    burstPositionSelectPin <= b;
    @(negedge ckPin);
    {loadFifoCmdPin, readTrainingCmdPin, writeTrainingCmdPin} <= 3'b000;
    addrPin <= ~a; // Released bus shows a changed value.
    burstPositionSelectPin <= ~b;
    repeat (gap) @(negedge ckPin);
  endtask : cmd
endmodule : tdf_ctl_model
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tdf_pkg::*;
;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic clk, rst_b, ce, wbCyc, wbStb, wbWe, wbAck, dqOe, inversionFlagOe;
  logic errorDetectOe, termOn, ckPin, ldCmd, rdCmd, wrCmd, holdDq;
  logic [7:0] wbAdr;
  logic [3:0] wbSel, inversionFlagIn, inversionFlagOut, errorDetectOut, bps;
  logic [31:0] wbDatI, wbDatO, dqIn, dqOut, q, prevDq, wVal;
  logic [9:0] addrPin;
  logic [9:0] pat [8];
  int ord [8];
  int nFail, nTests, i, k, t;
  tdf_ctl_model m (.ckPin(ckPin), .loadFifoCmdPin(ldCmd),
    .readTrainingCmdPin(rdCmd), .writeTrainingCmdPin(wrCmd),
    .addrPin(addrPin), .burstPositionSelectPin(bps));
  tdf_training_fifo dut (.clk(clk), .rst_b(rst_b), .ce(ce), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .ckPin(ckPin),
    .loadFifoCmdPin(ldCmd), .readTrainingCmdPin(rdCmd),
    .writeTrainingCmdPin(wrCmd), .addrPin(addrPin),
    .burstPositionSelectPin(bps), .dqIn(dqIn),
    .inversionFlagIn(inversionFlagIn), .dqOut(dqOut), .dqOe(dqOe),
    .inversionFlagOut(inversionFlagOut), .inversionFlagOe(inversionFlagOe),
    .errorDetectOut(errorDetectOut), .errorDetectOe(errorDetectOe),
    .termOn(termOn));
  // Makes the 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Write-training data changes every cycle unless held for a burst.
  always @(posedge clk) begin
    dqIn <= holdDq ? wVal : $urandom;
    inversionFlagIn <= 4'($urandom);
  end
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (nFail == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // Compares one value and counts it.
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One classic Wishbone cycle; waits a bounded time for the ack.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, a, 4'hf, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) begin
      nFail++;
      final_report();
    end
    q = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
    @(posedge clk);
  endtask : wb
  // Waits a bounded time for the data pins to drive.
  task automatic waitOe();
    int n;
    n = 0;
    while (dqOe !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (dqOe !== 1'b1) begin
      nFail++;
      final_report();
    end
  endtask : waitOe
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(84380));
    {rst_b, ce, holdDq} = 3'b010;
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = '0;
    {nFail, nTests} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    wb(1'b0, REG_ID, 32'h0);
    check("depth", {29'h0, q[2:0]}, 32'h6);
    wb(1'b0, REG_CTRL, 32'h0);
    check("ctrl", q, CTRL_RST);
    wb(1'b0, 8'h10, 32'h0);
    check("unmapped", q, 32'h0);
    wb(1'b1, REG_CTRL, 32'h0000_0a25);
    wb(1'b0, REG_CTRL, 32'h0);
    check("ctrlWr", q, 32'h0000_0a25);
    for (i = 0; i < 8; i++) begin
      ord[i] = i;
      pat[i] = 10'($urandom);
    end
    for (i = 6; i > 0; i--) begin
      k = $urandom_range(i, 0);
      {ord[i], ord[k]} = {ord[k], ord[i]};
    end
    for (i = 0; i < 8; i++) begin
      m.cmd(3'b100, pat[ord[i]], {1'($urandom), 3'(ord[i])}, 2);
      check("loadDqOe", {31'h0, dqOe}, 32'h0);
      check("loadEdc", {28'h0, errorDetectOut}, 32'ha);
      check("loadTerm", {31'h0, termOn}, 32'h1);
    end
    m.cmd(3'b100, pat[7], 4'h7, 2);
    wb(1'b0, REG_STAT, 32'h0);
    check("wrPtr", {29'h0, q[2:0]}, 32'h2);
    t = 0;
    fork
      begin
        m.cmd(3'b010, 10'h0, 4'h0, 0);
        m.cmd(3'b010, 10'h0, 4'h0, 4);
      end
      begin
        waitOe();
        check("beat0", dqOut, {4{pat[0][7:0]}});
        check("flagOe", {31'h0, inversionFlagOe}, 32'h1);
        check("termOff", {31'h0, termOn}, 32'h0);
        while (dqOe === 1'b1 && t < 100) begin
          prevDq = dqOut;
          t++;
          @(posedge clk);
        end
        check("ones", prevDq, 32'hffff_ffff);
        check("gapless", {31'h0, t > 45 && t < 60}, 32'h1);
        @(posedge clk);
        check("termOn", {31'h0, termOn}, 32'h1);
      end
    join
    wb(1'b0, REG_STAT, 32'h0);
    check("rdPtr", {29'h0, q[6:4]}, 32'h2);
    check("scratch", {31'h0, q[8]}, 32'h0);
    // One write-training burst of a held word into stage two, read back.
    wVal <= $urandom;
    holdDq <= 1'b1;
    m.cmd(3'b001, 10'h0, 4'h0, 8);
    m.cmd(3'b010, 10'h0, 4'h0, 0);
    waitOe();
    check("wrBeat0", dqOut, wVal);
    check("wrFlag", {28'h0, inversionFlagOut}, 32'hf);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
